//--- ilc_pkg.sv
`default_nettype none
package ilc_pkg;
    // Register indices; byte address on the bus is four times the index
    localparam logic [9:0] ILC_IDX_CODE_LEN = 10'h015;
    localparam logic [9:0] ILC_IDX_ACT_CODE = 10'h017;
    localparam logic [9:0] ILC_IDX_DEACT_CODE = 10'h018;
    localparam logic [9:0] ILC_IDX_LOOP = 10'h019;
    localparam logic [9:0] ILC_IDX_EDGE = 10'h01a;
    localparam logic [9:0] ILC_IDX_FLAG = 10'h020;
    localparam logic [9:0] ILC_IDX_MASK = 10'h021;
    localparam logic [9:0] ILC_IDX_STATE = 10'h022;

    // Reset values
    localparam logic [3:0] ILC_RST_LEN = 4'h1;
    localparam logic [7:0] ILC_RST_ACT = 8'h01;
    localparam logic [7:0] ILC_RST_DEACT = 8'h09;
    localparam logic [3:0] ILC_RST_LOOP = 4'h0;
    localparam logic [6:0] ILC_RST_EDGE = 7'h00;
    localparam logic [9:0] ILC_RST_MASK = 10'h3ff;

    // Loopback control fields
    localparam int ILC_LOOP_AUTO = 3;
    localparam int ILC_LOOP_DIG = 2;
    localparam int ILC_LOOP_REM = 1;
    localparam int ILC_LOOP_ANA = 0;
    // Code length fields
    localparam int ILC_LEN_ACT = 2;
    localparam int ILC_LEN_DEACT = 0;
    // Edge select fields
    localparam int ILC_ES_IB = 0;
    localparam int ILC_ES_LOS = 1;
    localparam int ILC_ES_TLOS = 2;
    localparam int ILC_ES_TCK = 3;
    localparam int ILC_ES_TOC = 4;
    localparam int ILC_ES_PA = 5;
    localparam int ILC_ES_AIS = 6;
    // Flag positions in the flag and mask registers
    localparam int ILC_F_LLOS = 0;
    localparam int ILC_F_SLOS = 1;
    localparam int ILC_F_TLOS = 2;
    localparam int ILC_F_TCK = 3;
    localparam int ILC_F_TOC = 4;
    localparam int ILC_F_PA = 5;
    localparam int ILC_F_LAIS = 6;
    localparam int ILC_F_SAIS = 7;
    localparam int ILC_F_IBD = 8;
    localparam int ILC_F_IBA = 9;
    localparam int ILC_NFLAG = 10;

    // Hold time before an automatic loopback change
    localparam int unsigned ILC_HOLD_MS = 5100;
    localparam int unsigned ILC_CLK_KHZ = 100000;
    localparam int unsigned ILC_HOLD_CYC = ILC_HOLD_MS * ILC_CLK_KHZ;
    localparam logic [1:0] ILC_LEN_BASE = 2'h3;

    typedef enum logic {
        ILC_LP_OFF,
        ILC_LP_ON
    } ilc_lp_type;

    // Code match on the low 5 to 8 bits; bit 0 holds the newest bit
    function automatic logic ilc_match(input logic [7:0] sh,
                                       input logic [7:0] code,
                                       input logic [1:0] len);
        logic [7:0] keep;
        keep = 8'hff >> (ILC_LEN_BASE - len);
        return ((sh ^ code) & keep) == 8'h00;
    endfunction : ilc_match

    // Byte-lane write of a narrow register; unused bits stay zero
    function automatic logic [7:0] ilc_wr8(input logic [7:0] old,
                                           input logic [7:0] dat,
                                           input logic sel,
                                           input logic [7:0] keep);
        return (sel ? dat : old) & keep;
    endfunction : ilc_wr8

    // Expand edge selects to one any-edge enable per flag
    function automatic logic [9:0] ilc_any_en(input logic [6:0] es);
        logic [9:0] en;
        en = 10'h000;
        en[ILC_F_LLOS] = es[ILC_ES_LOS];
        en[ILC_F_SLOS] = es[ILC_ES_LOS];
        en[ILC_F_TLOS] = es[ILC_ES_TLOS];
        en[ILC_F_TCK] = es[ILC_ES_TCK];
        en[ILC_F_TOC] = es[ILC_ES_TOC];
        en[ILC_F_PA] = es[ILC_ES_PA];
        en[ILC_F_LAIS] = es[ILC_ES_AIS];
        en[ILC_F_SAIS] = es[ILC_ES_AIS];
        en[ILC_F_IBD] = es[ILC_ES_IB];
        en[ILC_F_IBA] = es[ILC_ES_IB];
        return en;
    endfunction : ilc_any_en
endpackage : ilc_pkg
`default_nettype wire

//--- ilc_loop_ctrl.sv
`default_nettype none
// Notes on behaviour
// - Match received bits against activate code
// - Match received bits against deactivate code
// - One activate code register shared by both paths
// - Auto enter loopback after 5.1 s activate
// - Auto leave loopback after 5.1 s deactivate
// - Control bit 3 enables automatic loopback
// - Control bit 2 forces digital loopback
// - Control bit 1 forces remote loopback
// - Control bit 0 drives analog loopback output
// - AIS select: rising or either edge flags
// - Pattern-sync select: rising or either edge
// - Overcurrent select: rising or either edge
// - Clock-missing select: rising or either edge
// - Transmit signal-loss select: rising or either
// - Signal-loss select: line and system states
// - Inband select: activate and deactivate states
// - Length field 00..11 selects 5..8 bits
module ilc_loop_ctrl
    import ilc_pkg::*;
#(
    parameter int unsigned HOLD_CYC = ILC_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_bit_i,
    input wire logic tx_bit_en_i,
    input wire logic rx_bit_i,
    input wire logic rx_bit_en_i,
    input wire logic line_sigloss_state_i,
    input wire logic sys_sigloss_state_i,
    input wire logic tx_sigloss_state_i,
    input wire logic txclk_miss_state_i,
    input wire logic overcurrent_state_i,
    input wire logic patsync_state_i,
    input wire logic line_ais_state_i,
    input wire logic sys_ais_state_i,
    output logic dig_loop_o,
    output logic rem_loop_o,
    output logic ana_loop_o,
    output logic auto_loop_o,
    output logic [9:0] irq_flags_o,
    output logic irq_o
);

    typedef struct packed {
        logic [7:0] act_code;
        logic [7:0] deact_code;
        logic [1:0] act_len;
        logic [1:0] deact_len;
        logic [3:0] loop;
        logic [6:0] edge_sel;
        logic [9:0] flags;
        logic [9:0] mask;
        logic [9:0] prev;
        logic [7:0] sh_tx;
        logic [7:0] sh_rx;
        logic [3:0] hit;
        ilc_lp_type [1:0] lp;
        logic [1:0][31:0] cnt;
        logic ack;
        logic [31:0] dat;
        logic dig;
        logic rem;
        logic ana;
        logic auto_on;
        logic irq;
    } ilc_state_type;

    ilc_state_type st_ff;
    ilc_state_type nxt_st;
    logic [9:0] cur;
    logic [9:0] ev;
    logic [9:0] clr;
    logic [9:0] idx;
    logic take;
    logic wr;
    logic want;
    logic [31:0] rd;

    // Word index; bytes within a word are chosen by the lane selects
    assign idx = wb_adr_i[11:2];

    // Status bits as seen this cycle; inband states from either path
    always_comb begin
        cur = 10'h000;
        cur[ILC_F_LLOS] = line_sigloss_state_i;
        cur[ILC_F_SLOS] = sys_sigloss_state_i;
        cur[ILC_F_TLOS] = tx_sigloss_state_i;
        cur[ILC_F_TCK] = txclk_miss_state_i;
        cur[ILC_F_TOC] = overcurrent_state_i;
        cur[ILC_F_PA] = patsync_state_i;
        cur[ILC_F_LAIS] = line_ais_state_i;
        cur[ILC_F_SAIS] = sys_ais_state_i;
        cur[ILC_F_IBD] = st_ff.hit[1] | st_ff.hit[3];
        cur[ILC_F_IBA] = st_ff.hit[0] | st_ff.hit[2];
    end

    // Read mux; unmapped indices and reserved bits read zero
    always_comb begin
        rd = 32'h0000_0000;
        case (idx)
            ILC_IDX_CODE_LEN: rd[3:0] = {st_ff.act_len, st_ff.deact_len};
            ILC_IDX_ACT_CODE: rd[7:0] = st_ff.act_code;
            ILC_IDX_DEACT_CODE: rd[7:0] = st_ff.deact_code;
            ILC_IDX_LOOP: rd[3:0] = st_ff.loop;
            ILC_IDX_EDGE: rd[6:0] = st_ff.edge_sel;
            ILC_IDX_FLAG: rd[9:0] = st_ff.flags;
            ILC_IDX_MASK: rd[9:0] = st_ff.mask;
            ILC_IDX_STATE: rd[5:0] = {st_ff.lp[1] == ILC_LP_ON,
                                      st_ff.lp[0] == ILC_LP_ON,
                                      cur[ILC_F_IBA], cur[ILC_F_IBD],
                                      st_ff.hit[2], st_ff.hit[0]};
            default: rd = 32'h0000_0000;
        endcase
    end

    // Next state: bus, code matching, edge flags, automatic loopback
    always_comb begin
        nxt_st = st_ff;
        take = wb_cyc_i & wb_stb_i & ~st_ff.ack;
        // A write commits only at the edge where the master sees ack, so
        // a cycle dropped before its answer never changes a register
        wr = wb_cyc_i & wb_stb_i & wb_we_i & st_ff.ack;
        want = 1'b0;
        nxt_st.ack = take;
        nxt_st.dat = take ? rd : 32'h0000_0000;

        // Writes land at the edge where ack is sampled high
        if (wr) begin
            case (idx)
                ILC_IDX_CODE_LEN: begin
                    if (wb_sel_i[0]) begin
                        nxt_st.act_len = wb_dat_i[ILC_LEN_ACT +: 2];
                        nxt_st.deact_len = wb_dat_i[ILC_LEN_DEACT +: 2];
                    end
                end
                ILC_IDX_ACT_CODE: nxt_st.act_code = ilc_wr8(st_ff.act_code,
                    wb_dat_i[7:0], wb_sel_i[0], 8'hff);
                ILC_IDX_DEACT_CODE: nxt_st.deact_code = ilc_wr8(
                    st_ff.deact_code, wb_dat_i[7:0], wb_sel_i[0], 8'hff);
                ILC_IDX_LOOP: nxt_st.loop = 4'(ilc_wr8({4'h0, st_ff.loop},
                    wb_dat_i[7:0], wb_sel_i[0], 8'h0f));
                ILC_IDX_EDGE: nxt_st.edge_sel = 7'(ilc_wr8(
                    {1'b0, st_ff.edge_sel}, wb_dat_i[7:0], wb_sel_i[0],
                    8'h7f));
                ILC_IDX_MASK: begin
                    if (wb_sel_i[0]) nxt_st.mask[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) nxt_st.mask[9:8] = wb_dat_i[9:8];
                end
                default: nxt_st.loop = st_ff.loop;
            endcase
        end

        // Write-one-to-clear of flags, per byte lane
        clr = 10'h000;
        if (wr && idx == ILC_IDX_FLAG) begin
            clr = {wb_sel_i[1] ? wb_dat_i[9:8] : 2'h0,
                   wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
        end

        // Serial shifters; newest bit sits in bit 0
        if (tx_bit_en_i) nxt_st.sh_tx = {st_ff.sh_tx[6:0], tx_bit_i};
        if (rx_bit_en_i) nxt_st.sh_rx = {st_ff.sh_rx[6:0], rx_bit_i};
        nxt_st.hit[0] = ilc_match(st_ff.sh_tx, st_ff.act_code,
                                  st_ff.act_len);
        nxt_st.hit[1] = ilc_match(st_ff.sh_tx, st_ff.deact_code,
                                  st_ff.deact_len);
        nxt_st.hit[2] = ilc_match(st_ff.sh_rx, st_ff.act_code,
                                  st_ff.act_len);
        nxt_st.hit[3] = ilc_match(st_ff.sh_rx, st_ff.deact_code,
                                  st_ff.deact_len);

        // Rising edges always count, falling ones only where selected
        ev = (cur & ~st_ff.prev) |
             ((cur ^ st_ff.prev) & ilc_any_en(st_ff.edge_sel));
        nxt_st.prev = cur;
        // A new event beats a clear in the same cycle
        nxt_st.flags = (st_ff.flags & ~clr) | ev;

        // Path 0 is transmit (digital), path 1 receive (remote)
        for (int p = 0; p < 2; p++) begin
            case (st_ff.lp[p])
                ILC_LP_OFF: want = st_ff.hit[2 * p];
                ILC_LP_ON: want = st_ff.hit[2 * p + 1];
                default: want = 1'b0;
            endcase
            if (!st_ff.loop[ILC_LOOP_AUTO]) begin
                nxt_st.lp[p] = ILC_LP_OFF;
                nxt_st.cnt[p] = 32'h0000_0000;
            end else if (!want) begin
                // Any break in the code restarts the hold time
                nxt_st.cnt[p] = 32'h0000_0000;
            end else if (st_ff.cnt[p] == 32'(HOLD_CYC)) begin
                nxt_st.lp[p] = (st_ff.lp[p] == ILC_LP_OFF) ?
                               ILC_LP_ON : ILC_LP_OFF;
                nxt_st.cnt[p] = 32'h0000_0000;
            end else begin
                nxt_st.cnt[p] = st_ff.cnt[p] + 32'h0000_0001;
            end
        end

        // Registered outputs follow the next state, so no extra lag
        nxt_st.dig = nxt_st.loop[ILC_LOOP_DIG] |
                     (nxt_st.lp[0] == ILC_LP_ON);
        nxt_st.rem = nxt_st.loop[ILC_LOOP_REM] |
                     (nxt_st.lp[1] == ILC_LP_ON);
        nxt_st.ana = nxt_st.loop[ILC_LOOP_ANA];
        nxt_st.auto_on = (nxt_st.lp[0] == ILC_LP_ON) |
                         (nxt_st.lp[1] == ILC_LP_ON);
        nxt_st.irq = |(nxt_st.flags & ~nxt_st.mask);
    end

    // State register; reset restores every documented default
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '0;
            st_ff.act_code <= ILC_RST_ACT;
            st_ff.deact_code <= ILC_RST_DEACT;
            st_ff.act_len <= ILC_RST_LEN[ILC_LEN_ACT +: 2];
            st_ff.deact_len <= ILC_RST_LEN[ILC_LEN_DEACT +: 2];
            st_ff.loop <= ILC_RST_LOOP;
            st_ff.edge_sel <= ILC_RST_EDGE;
            st_ff.mask <= ILC_RST_MASK;
            st_ff.lp[0] <= ILC_LP_OFF;
            st_ff.lp[1] <= ILC_LP_OFF;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign dig_loop_o = st_ff.dig;
    assign rem_loop_o = st_ff.rem;
    assign ana_loop_o = st_ff.ana;
    assign auto_loop_o = st_ff.auto_on;
    assign irq_flags_o = st_ff.flags;
    assign irq_o = st_ff.irq;

    default clocking dflt_cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_act_match: assert property (
        tx_bit_en_i ##1 (st_ff.sh_tx == st_ff.act_code && st_ff.act_len
            == 2'h3) |=> st_ff.hit[0])
        else $error("activate code not matched");
    a_deact_match: assert property (
        st_ff.hit[3] |-> ilc_match($past(st_ff.sh_rx),
            $past(st_ff.deact_code), $past(st_ff.deact_len)))
        else $error("deactivate hit without match");
    a_auto_enter: assert property (
        (st_ff.loop[ILC_LOOP_AUTO] && st_ff.lp[0] == ILC_LP_OFF &&
            st_ff.hit[0] && st_ff.cnt[0] == 32'(HOLD_CYC)) |=>
            (dig_loop_o && auto_loop_o))
        else $error("automatic digital loopback not entered");
    a_auto_hold: assert property (
        $rose(st_ff.lp[1] == ILC_LP_ON) |->
            $past(st_ff.cnt[1]) == 32'(HOLD_CYC) && $past(st_ff.hit[2]))
        else $error("remote loopback entered early");
    a_auto_leave: assert property (
        (st_ff.loop[ILC_LOOP_AUTO] && st_ff.lp[1] == ILC_LP_ON &&
            st_ff.hit[3] && st_ff.cnt[1] == 32'(HOLD_CYC) &&
            !st_ff.loop[ILC_LOOP_REM]) |=> !rem_loop_o)
        else $error("automatic remote loopback not left");
    a_auto_off: assert property (
        !st_ff.loop[ILC_LOOP_AUTO] |=> !auto_loop_o)
        else $error("automatic loopback while disabled");
    a_dig_force: assert property (
        st_ff.loop[ILC_LOOP_DIG] |-> dig_loop_o)
        else $error("digital loopback not forced");
    a_rem_force: assert property (
        st_ff.loop[ILC_LOOP_REM] |-> rem_loop_o)
        else $error("remote loopback not forced");
    a_ana_follow: assert property (
        ana_loop_o == st_ff.loop[ILC_LOOP_ANA])
        else $error("analog loopback output wrong");
    a_ais_rise: assert property (
        (sys_ais_state_i && !st_ff.prev[ILC_F_SAIS]) |=>
            irq_flags_o[ILC_F_SAIS])
        else $error("system AIS rise not flagged");
    a_pa_fall: assert property (
        (!patsync_state_i && st_ff.prev[ILC_F_PA] &&
            st_ff.edge_sel[ILC_ES_PA]) |=> irq_flags_o[ILC_F_PA])
        else $error("pattern-sync fall not flagged");
    a_toc_fall_skip: assert property (
        (!overcurrent_state_i && !st_ff.edge_sel[ILC_ES_TOC] &&
            !irq_flags_o[ILC_F_TOC]) |=> !irq_flags_o[ILC_F_TOC])
        else $error("overcurrent fall flagged on rise select");
    a_flag_sticky: assert property (
        !wb_stb_i |=> (irq_flags_o & $past(irq_flags_o)) ==
            $past(irq_flags_o))
        else $error("flag dropped without a clear");
    a_resv_zero: assert property (
        (wb_ack_o && !wb_we_i && wb_adr_i[11:2] == ILC_IDX_LOOP) |->
            wb_dat_o[31:4] == 28'h0000000)
        else $error("reserved loop bits not zero");
    a_ack_once: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_loop_write: assert property (
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
            wb_adr_i[11:2] == ILC_IDX_LOOP) |=>
            st_ff.loop == $past(wb_dat_i[3:0]))
        else $error("loop control write lost");
    a_edge_write: assert property (
        (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
            wb_adr_i[11:2] == ILC_IDX_EDGE) |=>
            st_ff.edge_sel == $past(wb_dat_i[6:0]))
        else $error("edge select write lost");
    a_tck_rise: assert property (
        (txclk_miss_state_i && !st_ff.prev[ILC_F_TCK]) |=>
            irq_flags_o[ILC_F_TCK])
        else $error("clock-missing rise not flagged");
    a_tlos_fall: assert property (
        (!tx_sigloss_state_i && st_ff.prev[ILC_F_TLOS] &&
            st_ff.edge_sel[ILC_ES_TLOS]) |=> irq_flags_o[ILC_F_TLOS])
        else $error("transmit signal-loss fall not flagged");
    a_los_fall: assert property (
        (!line_sigloss_state_i && st_ff.prev[ILC_F_LLOS] &&
            st_ff.edge_sel[ILC_ES_LOS]) |=> irq_flags_o[ILC_F_LLOS])
        else $error("line signal-loss fall not flagged");
    a_ib_rise: assert property (
        (st_ff.hit[0] && !st_ff.prev[ILC_F_IBA]) |=>
            irq_flags_o[ILC_F_IBA])
        else $error("activate code rise not flagged");
    a_len_seven: assert property (
        (st_ff.act_len == 2'h2 && st_ff.sh_rx[6:0] ==
            st_ff.act_code[6:0]) |=> st_ff.hit[2])
        else $error("seven-bit activate code not matched");
    a_len_five: assert property (
        (st_ff.deact_len == 2'h0 && st_ff.sh_tx[4:0] ==
            st_ff.deact_code[4:0]) |=> st_ff.hit[1])
        else $error("five-bit deactivate code not matched");
    a_irq_level: assert property (
        irq_o == |(irq_flags_o & ~st_ff.mask))
        else $error("interrupt level wrong");

endmodule : ilc_loop_ctrl
`default_nettype wire

//--- inband_loop_ctrl_edge_select_tb.sv
`default_nettype none
module inband_loop_ctrl_edge_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ilc_pkg::*;
    // Short hold so the automatic loopback fits a quick run
    localparam int unsigned HOLD = 20;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic tx_bit_i = 1'b0;
    logic tx_bit_en_i = 1'b0;
    logic rx_bit_i = 1'b0;
    logic rx_bit_en_i = 1'b0;
    logic [7:0] st = 8'h00;
    logic dig_loop_o, rem_loop_o, ana_loop_o, auto_loop_o, irq_o;
    logic [9:0] irq_flags_o;
    logic [31:0] exp_q[$];
    int err_count = 0;
    int n_checks = 0;
    logic [31:0] r;

    ilc_loop_ctrl #(.HOLD_CYC(HOLD)) ilc_loop_ctrl_i (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .tx_bit_i(tx_bit_i),
        .tx_bit_en_i(tx_bit_en_i), .rx_bit_i(rx_bit_i),
        .rx_bit_en_i(rx_bit_en_i), .line_sigloss_state_i(st[0]),
        .sys_sigloss_state_i(st[1]), .tx_sigloss_state_i(st[2]),
        .txclk_miss_state_i(st[3]), .overcurrent_state_i(st[4]),
        .patsync_state_i(st[5]), .line_ais_state_i(st[6]),
        .sys_ais_state_i(st[7]), .dig_loop_o(dig_loop_o),
        .rem_loop_o(rem_loop_o), .ana_loop_o(ana_loop_o),
        .auto_loop_o(auto_loop_o), .irq_flags_o(irq_flags_o),
        .irq_o(irq_o)
    );

    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;

    task automatic report_and_stop();
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One classic cycle; a read leaves its expectation for the monitor
    task automatic wb(input logic w, input logic [9:0] idx,
                      input logic [31:0] d, input logic [31:0] exp);
        if (!w) begin
            exp_q.push_back(exp);
        end
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Both paths receive the same bit every cycle
    task automatic feed(input logic b, input int n);
        tx_bit_i <= b;
        rx_bit_i <= b;
        tx_bit_en_i <= 1'b1;
        rx_bit_en_i <= 1'b1;
        repeat (n) @(posedge clk_i);
    endtask : feed

    // Edge select bit that governs each status input
    function automatic int es_of(input int i);
        if (i < 2) return ILC_ES_LOS;
        if (i > 5) return ILC_ES_AIS;
        return i;
    endfunction : es_of

    // Read data is taken at the edge where ack is seen high
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk("unexpected read", 32'h1, 32'h0);
            end else begin
                chk("read data", wb_dat_o, exp_q.pop_front());
            end
        end
    end

    // A hang counts as a failure
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(66725));
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        wb(0, ILC_IDX_ACT_CODE, 0, 32'h01);
        wb(0, ILC_IDX_DEACT_CODE, 0, 32'h09);
        wb(0, ILC_IDX_LOOP, 0, 32'h00);
        wb(0, ILC_IDX_EDGE, 0, 32'h00);
        wb(0, ILC_IDX_CODE_LEN, 0, 32'h01);
        wb(0, 10'h030, 0, 32'h0);
        // Random values, reserved bits must read back as zero
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            // Auto bit kept off: a stray code hit must not start a loop
            wb(1, ILC_IDX_LOOP, r & ~32'h8, 0);
            wb(0, ILC_IDX_LOOP, 0, r & 32'h7);
            chk("dig_loop", dig_loop_o, r[2]);
            chk("rem_loop", rem_loop_o, r[1]);
            chk("ana_loop", ana_loop_o, r[0]);
            chk("auto idle", auto_loop_o, 0);
            wb(1, ILC_IDX_EDGE, r, 0);
            wb(0, ILC_IDX_EDGE, 0, r & 32'h7f);
            wb(1, ILC_IDX_ACT_CODE, r >> 8, 0);
            wb(0, ILC_IDX_ACT_CODE, 0, (r >> 8) & 32'hff);
            wb(1, ILC_IDX_DEACT_CODE, r >> 16, 0);
            wb(0, ILC_IDX_DEACT_CODE, 0, (r >> 16) & 32'hff);
        end
        wb(1, ILC_IDX_LOOP, 0, 0);
        // Rising edge always flags; falling only with its select set
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 8; i++) begin
                wb(1, ILC_IDX_EDGE, s ? (32'h1 << es_of(i)) : 0, 0);
                wb(1, ILC_IDX_FLAG, 32'h3ff, 0);
                st[i] <= 1'b1;
                repeat (3) @(posedge clk_i);
                chk("flag pins", irq_flags_o, 32'h1 << i);
                wb(0, ILC_IDX_FLAG, 0, 32'h1 << i);
                wb(1, ILC_IDX_FLAG, 32'h3ff, 0);
                st[i] <= 1'b0;
                repeat (3) @(posedge clk_i);
                chk("flag pins", irq_flags_o, s ? (32'h1 << i) : 0);
                wb(0, ILC_IDX_FLAG, 0, s ? (32'h1 << i) : 0);
            end
        end
        // All-ones activate and all-zeros deactivate, 8 bits long
        wb(1, ILC_IDX_LOOP, 32'h8, 0);
        wb(1, ILC_IDX_CODE_LEN, 32'hf, 0);
        wb(1, ILC_IDX_ACT_CODE, 32'hff, 0);
        wb(1, ILC_IDX_DEACT_CODE, 32'h00, 0);
        wb(1, ILC_IDX_EDGE, 0, 0);
        wb(1, ILC_IDX_FLAG, 32'h3ff, 0);
        feed(1'b1, 15);
        chk("auto early", auto_loop_o, 0);
        feed(1'b1, 30);
        chk("auto enter", auto_loop_o, 1);
        wb(0, ILC_IDX_STATE, 0, 32'h3b);
        wb(0, ILC_IDX_FLAG, 0, 32'h200);
        feed(1'b0, 15);
        chk("auto hold", auto_loop_o, 1);
        feed(1'b0, 30);
        chk("auto leave", auto_loop_o, 0);
        wb(0, ILC_IDX_STATE, 0, 32'h04);
        // Short codes: bits above the selected length must be ignored
        wb(1, ILC_IDX_LOOP, 32'h0, 0);
        wb(1, ILC_IDX_CODE_LEN, 32'h8, 0);
        wb(0, ILC_IDX_CODE_LEN, 0, 32'h8);
        wb(1, ILC_IDX_ACT_CODE, 32'h7f, 0);
        wb(1, ILC_IDX_DEACT_CODE, 32'hdf, 0);
        feed(1'b1, 10);
        wb(0, ILC_IDX_STATE, 0, 32'h0f);
        tx_bit_en_i <= 1'b0;
        rx_bit_en_i <= 1'b0;
        // Level interrupt follows unmasked sticky flags
        wb(1, ILC_IDX_FLAG, 32'h3ff, 0);
        wb(1, ILC_IDX_MASK, 32'h3fe, 0);
        st[0] <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("irq set", irq_o, 1);
        wb(1, ILC_IDX_MASK, 32'h3ff, 0);
        chk("irq masked", irq_o, 0);
        wb(1, ILC_IDX_MASK, 32'h3fe, 0);
        chk("irq unmasked", irq_o, 1);
        wb(1, ILC_IDX_FLAG, 32'h1, 0);
        chk("irq cleared", irq_o, 0);
        st[0] <= 1'b0;
        // Second reset in mid-run restores every field
        wb(1, ILC_IDX_LOOP, 32'h7, 0);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        chk("dig after reset", dig_loop_o, 0);
        wb(0, ILC_IDX_LOOP, 0, 32'h0);
        wb(0, ILC_IDX_ACT_CODE, 0, 32'h01);
        wb(0, ILC_IDX_MASK, 0, 32'h3ff);
        repeat (2) @(posedge clk_i);
        chk("reads pending", exp_q.size(), 0);
        report_and_stop();
    end
endmodule : inband_loop_ctrl_edge_select_tb
`default_nettype wire
